/* File: hw/pfs_top.sv */
/*
 * pin function selector for six pins: port a pins 0,1,2,7 and port b
 * pins 3,4. routes timer channels, serial controller pins and the
 * external regulator enable, else general-purpose port logic.
 * assumes settings from software registers, inputs synchronous to clk.
 */
// Overview of operation
// - remap bit 6: timer-two ch3 on port b pin 3, else port a pin 1
// - remap bit 7 set puts timer-two ch4 on port b pin 4
// - remap bit 7 clear puts timer-two ch4 on port a pin 2
// - timer-two ch1 uses port a pin 0 only while remap bit 4 clear
// - timer drives pin only with output enabled and alternate function set
// - ser1 spi clock on port b pin 3 unless ch3 output owns it
// - ser1 request-to-send on port b pin 4 unless ch4 output owns it
// - ser2 spi mosi on port a pin 0 unless ch1 output owns it
// - ser2 two-wire data and miso on port a pin 1 unless ch3 owns it
// - spi config bit 4 picks master or slave pin directions
// - ser1 handshake only in uart mode with uart config bit 5 set
// - two-wire data is open-drain when the pin selects alt open-drain
// - port a pin 7 is regulator enable until debug config bit 4 is set
// - port b pin 4 is ser1 slave select in spi slave mode
`timescale 1ns/10ps
`default_nettype none
`include "pfs_cfg.svh"

module pfs_top
    import pfs_pkg::*;
#(
    parameter int N = `PFS_NUM_PINS
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // timer settings
    input wire logic [7:0] timer_two_remap,
    input wire logic [3:0] timer_two_output_enables,
    input wire logic [3:0] timer_one_output_enables,
    // port settings
    input wire logic [15:0] port_a_low_config,
    input wire logic [15:0] port_a_high_config,
    input wire logic [15:0] port_b_low_config,
    input wire logic [15:0] port_b_high_config,
    input wire logic [7:0] debug_pin_config,
    // serial controller settings
    input wire logic [1:0] ser1_mode_select,
    input wire logic [1:0] ser2_mode_select,
    input wire logic [7:0] ser1_spi_config,
    input wire logic [7:0] ser2_spi_config,
    input wire logic [7:0] ser1_uart_config,
    // timer channels
    input wire logic timer_two_ch1_out,
    input wire logic timer_two_ch3_out,
    input wire logic timer_two_ch4_out,
    input wire logic timer_one_ch4_out,
    output logic timer_two_ch1_in,
    output logic timer_two_ch3_in,
    output logic timer_two_ch4_in,
    output logic timer_one_ch4_in,
    // serial controller one
    input wire logic ser1_spi_clock_out,
    output logic ser1_spi_clock_in,
    input wire logic ser1_request_to_send_n,
    output logic ser1_clear_to_send_n,
    output logic ser1_slave_select_n,
    // serial controller two
    input wire logic ser2_spi_mosi_out,
    output logic ser2_spi_mosi_in,
    input wire logic ser2_spi_miso_out,
    output logic ser2_spi_miso_in,
    input wire logic ser2_twowire_data_out,
    output logic ser2_twowire_data_in,
    // regulator control level, high enables the regulator
    input wire logic ext_reg_enable,
    // general-purpose port logic, one bit per pin slot
    input wire logic [N-1:0] gpio_out,
    output logic [N-1:0] gpio_in,
    // pads
    input wire logic [N-1:0] pad_in,
    output logic [N-1:0] pad_out,
    output logic [N-1:0] pad_oe
);
    pfs_alt_if #(.N(N)) req ();

    logic [3:0] cfg [N];
    logic ch1_here;
    logic ch3_on_b;
    logic ch4_on_b;
    logic t2_ch1_drv;
    logic t2_ch3_drv;
    logic t2_ch4_drv;
    logic t1_ch4_drv;
    logic ch1_owns_pa0;
    logic ch3_owns_pa1;
    logic ch3_owns_pb3;
    logic ch4_owns_pb4;
    logic reg_en_forced;
    logic s1_hs;
    logic s1_master;
    logic s1_slave;
    logic s2_master;
    logic s2_slave;
    logic s2_twi;
    logic [N-1:0] en_d;
    logic [N-1:0] val_d;
    logic [N-1:0] od_d;

    // per-pin config fields
    always_comb begin
        cfg[`PFS_PA0] = port_a_low_config[`PFS_PA0_FLD +: 4];
        cfg[`PFS_PA1] = port_a_low_config[`PFS_PA1_FLD +: 4];
        cfg[`PFS_PA2] = port_a_low_config[`PFS_PA2_FLD +: 4];
        cfg[`PFS_PA7] = port_a_high_config[`PFS_PA7_FLD +: 4];
        cfg[`PFS_PB3] = port_b_low_config[`PFS_PB3_FLD +: 4];
        cfg[`PFS_PB4] = port_b_high_config[`PFS_PB4_FLD +: 4];
    end

    // serial controller one roles
    pfs_ser_mode u_ser1 (
        .mode(ser1_mode_select),
        .spi_master_bit(ser1_spi_config[`PFS_SPI_MASTER]),
        .uart_hs_bit(ser1_uart_config[`PFS_UART_HS]),
        .uart_hs(s1_hs),
        .spi_master(s1_master),
        .spi_slave(s1_slave),
        .twi()
    );

    // serial controller two roles
    pfs_ser_mode u_ser2 (
        .mode(ser2_mode_select),
        .spi_master_bit(ser2_spi_config[`PFS_SPI_MASTER]),
        .uart_hs_bit(1'b0),
        .uart_hs(),
        .spi_master(s2_master),
        .spi_slave(s2_slave),
        .twi(s2_twi)
    );

    // timer channel placement from the remap bits
    assign ch1_here = !timer_two_remap[`PFS_REMAP_CH1];
    assign ch3_on_b = timer_two_remap[`PFS_REMAP_CH3];
    assign ch4_on_b = timer_two_remap[`PFS_REMAP_CH4];

    // channel output enables from the capture-compare enables
    assign t2_ch1_drv = timer_two_output_enables[`PFS_OE_CH1];
    assign t2_ch3_drv = timer_two_output_enables[`PFS_OE_CH3];
    assign t2_ch4_drv = timer_two_output_enables[`PFS_OE_CH4];
    assign t1_ch4_drv = timer_one_output_enables[`PFS_OE_CH4];

    // pin ownership by an enabled timer output; serial pins yield to it
    assign ch1_owns_pa0 = t2_ch1_drv && ch1_here;
    assign ch3_owns_pa1 = t2_ch3_drv && !ch3_on_b;
    assign ch3_owns_pb3 = t2_ch3_drv && ch3_on_b;
    assign ch4_owns_pb4 = t2_ch4_drv && ch4_on_b;

    // regulator enable holds port a pin 7 until released
    assign reg_en_forced = !debug_pin_config[`PFS_DBG_REG_OFF];

    // port a pin 0: timer-two ch1, else ser2 mosi as master, else port
    always_comb begin
        en_d[`PFS_PA0] = 1'b0;
        val_d[`PFS_PA0] = 1'b0;
        od_d[`PFS_PA0] = pfs_is_od(cfg[`PFS_PA0]);
        if (pfs_is_alt(cfg[`PFS_PA0])) begin
            if (ch1_owns_pa0) begin
                en_d[`PFS_PA0] = 1'b1;
                val_d[`PFS_PA0] = timer_two_ch1_out;
            end else if (s2_master) begin
                en_d[`PFS_PA0] = 1'b1;
                val_d[`PFS_PA0] = ser2_spi_mosi_out;
            end
        end else if (pfs_is_gpio(cfg[`PFS_PA0])) begin
            en_d[`PFS_PA0] = 1'b1;
            val_d[`PFS_PA0] = gpio_out[`PFS_PA0];
        end
    end

    // port a pin 1: timer-two ch3, else ser2 two-wire or miso, else port
    always_comb begin
        en_d[`PFS_PA1] = 1'b0;
        val_d[`PFS_PA1] = 1'b0;
        od_d[`PFS_PA1] = pfs_is_od(cfg[`PFS_PA1]);
        if (pfs_is_alt(cfg[`PFS_PA1])) begin
            if (ch3_owns_pa1) begin
                en_d[`PFS_PA1] = 1'b1;
                val_d[`PFS_PA1] = timer_two_ch3_out;
            end else if (s2_twi) begin
                // only an open-drain field may carry the data line
                en_d[`PFS_PA1] = cfg[`PFS_PA1] == `PFS_CFG_ALT_OD;
                val_d[`PFS_PA1] = ser2_twowire_data_out;
            end else if (s2_slave) begin
                en_d[`PFS_PA1] = 1'b1;
                val_d[`PFS_PA1] = ser2_spi_miso_out;
            end
        end else if (pfs_is_gpio(cfg[`PFS_PA1])) begin
            en_d[`PFS_PA1] = 1'b1;
            val_d[`PFS_PA1] = gpio_out[`PFS_PA1];
        end
    end

    // port a pin 2: timer-two ch4 when not remapped, else port
    always_comb begin
        en_d[`PFS_PA2] = 1'b0;
        val_d[`PFS_PA2] = 1'b0;
        od_d[`PFS_PA2] = pfs_is_od(cfg[`PFS_PA2]);
        if (pfs_is_alt(cfg[`PFS_PA2])) begin
            en_d[`PFS_PA2] = t2_ch4_drv && !ch4_on_b;
            val_d[`PFS_PA2] = timer_two_ch4_out;
        end else if (pfs_is_gpio(cfg[`PFS_PA2])) begin
            en_d[`PFS_PA2] = 1'b1;
            val_d[`PFS_PA2] = gpio_out[`PFS_PA2];
        end
    end

    // port a pin 7: regulator enable first, then timer-one ch4 or port
    always_comb begin
        en_d[`PFS_PA7] = 1'b0;
        val_d[`PFS_PA7] = 1'b0;
        od_d[`PFS_PA7] = pfs_is_od(cfg[`PFS_PA7]);
        if (reg_en_forced) begin
            // open-drain, pulled low while the regulator is off
            en_d[`PFS_PA7] = 1'b1;
            val_d[`PFS_PA7] = ext_reg_enable;
            od_d[`PFS_PA7] = 1'b1;
        end else if (pfs_is_alt(cfg[`PFS_PA7])) begin
            en_d[`PFS_PA7] = t1_ch4_drv;
            val_d[`PFS_PA7] = timer_one_ch4_out;
        end else if (pfs_is_gpio(cfg[`PFS_PA7])) begin
            en_d[`PFS_PA7] = 1'b1;
            val_d[`PFS_PA7] = gpio_out[`PFS_PA7];
        end
    end

    // port b pin 3: timer-two ch3 when remapped, else ser1 clock, else port
    always_comb begin
        en_d[`PFS_PB3] = 1'b0;
        val_d[`PFS_PB3] = 1'b0;
        od_d[`PFS_PB3] = pfs_is_od(cfg[`PFS_PB3]);
        if (pfs_is_alt(cfg[`PFS_PB3])) begin
            if (ch3_owns_pb3) begin
                en_d[`PFS_PB3] = 1'b1;
                val_d[`PFS_PB3] = timer_two_ch3_out;
            end else if (s1_master) begin
                en_d[`PFS_PB3] = 1'b1;
                val_d[`PFS_PB3] = ser1_spi_clock_out;
            end
        end else if (pfs_is_gpio(cfg[`PFS_PB3])) begin
            en_d[`PFS_PB3] = 1'b1;
            val_d[`PFS_PB3] = gpio_out[`PFS_PB3];
        end
    end

    // port b pin 4: timer-two ch4 when remapped, else ser1 rts, else port
    always_comb begin
        en_d[`PFS_PB4] = 1'b0;
        val_d[`PFS_PB4] = 1'b0;
        od_d[`PFS_PB4] = pfs_is_od(cfg[`PFS_PB4]);
        if (pfs_is_alt(cfg[`PFS_PB4])) begin
            if (ch4_owns_pb4) begin
                en_d[`PFS_PB4] = 1'b1;
                val_d[`PFS_PB4] = timer_two_ch4_out;
            end else if (s1_hs) begin
                en_d[`PFS_PB4] = 1'b1;
                val_d[`PFS_PB4] = ser1_request_to_send_n;
            end
        end else if (pfs_is_gpio(cfg[`PFS_PB4])) begin
            en_d[`PFS_PB4] = 1'b1;
            val_d[`PFS_PB4] = gpio_out[`PFS_PB4];
        end
    end

    // hand the drive requests to the pad bank
    assign req.en = en_d;
    assign req.val = val_d;
    assign req.od = od_d;

    pfs_pad_bank #(.N(N)) u_pads (
        .clk(clk),
        .srst(srst),
        .req(req),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .pin_q(gpio_in)
    );

    // timer channel inputs follow the channel's current pin
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_two_ch1_in <= 1'b0;
            timer_two_ch3_in <= 1'b0;
            timer_two_ch4_in <= 1'b0;
            timer_one_ch4_in <= 1'b0;
        end else begin
            timer_two_ch1_in <= ch1_here && pad_in[`PFS_PA0];
            timer_two_ch3_in <= ch3_on_b ? pad_in[`PFS_PB3]
                                         : pad_in[`PFS_PA1];
            timer_two_ch4_in <= ch4_on_b ? pad_in[`PFS_PB4]
                                         : pad_in[`PFS_PA2];
            timer_one_ch4_in <= pad_in[`PFS_PA7];
        end
    end

    // serial controller one inputs; idle levels when the role is off
    always_ff @(posedge clk) begin
        if (srst) begin
            ser1_spi_clock_in <= 1'b0;
            ser1_clear_to_send_n <= 1'b0;
            ser1_slave_select_n <= 1'b1;
        end else begin
            ser1_spi_clock_in <= s1_slave && pad_in[`PFS_PB3];
            // without handshake the sender is always cleared
            ser1_clear_to_send_n <= s1_hs && pad_in[`PFS_PB3];
            ser1_slave_select_n <= !s1_slave
                                   || pad_in[`PFS_PB4];
        end
    end

    // serial controller two inputs; idle levels when the role is off
    always_ff @(posedge clk) begin
        if (srst) begin
            ser2_spi_mosi_in <= 1'b0;
            ser2_spi_miso_in <= 1'b0;
            ser2_twowire_data_in <= 1'b1;
        end else begin
            ser2_spi_mosi_in <= s2_slave && pad_in[`PFS_PA0];
            ser2_spi_miso_in <= s2_master && pad_in[`PFS_PA1];
            // idle-high line when two-wire mode is off
            ser2_twowire_data_in <= !s2_twi || pad_in[`PFS_PA1];
        end
    end
endmodule

`default_nettype wire

/* File: inc/pfs_cfg.svh */
/*
 * constants of the pin function selector: pin slots, config field
 * positions, pin mode codes and control bit positions.
 * assumes inclusion by bare name, once per compilation unit.
 */
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// pin slots on the pad bank
`define PFS_NUM_PINS 6
`define PFS_PA0 0
`define PFS_PA1 1
`define PFS_PA2 2
`define PFS_PA7 3
`define PFS_PB3 4
`define PFS_PB4 5

// lsb of each pin's 4-bit field in its port config word
`define PFS_PA0_FLD 0
`define PFS_PA1_FLD 4
`define PFS_PA2_FLD 8
`define PFS_PA7_FLD 12
`define PFS_PB3_FLD 12
`define PFS_PB4_FLD 0

// pin mode codes of a config field
`define PFS_CFG_ANALOG 4'h0
`define PFS_CFG_OUT 4'h1
`define PFS_CFG_OUT_OD 4'h5
`define PFS_CFG_IN 4'h4
`define PFS_CFG_IN_PULL 4'h8
`define PFS_CFG_ALT 4'h9
`define PFS_CFG_ALT_OD 4'hd

// control bit positions
`define PFS_REMAP_CH1 4
`define PFS_REMAP_CH3 6
`define PFS_REMAP_CH4 7
`define PFS_SPI_MASTER 4
`define PFS_UART_HS 5
`define PFS_DBG_REG_OFF 4

// output enable bit per timer channel (channel n at bit n-1)
`define PFS_OE_CH1 0
`define PFS_OE_CH3 2
`define PFS_OE_CH4 3

`endif

/* File: inc/pfs_pkg.sv */
/*
 * types and pin mode decoders of the pin function selector.
 * assumes pfs_cfg.svh on the include path.
 */
`include "pfs_cfg.svh"

package pfs_pkg;

    // serial controller operating mode, in mode select encoding
    typedef enum logic [1:0] {
        PFS_MODE_OFF,
        PFS_MODE_UART,
        PFS_MODE_SPI,
        PFS_MODE_TWI
    } pfs_mode_t;

    // field selects a peripheral output (push-pull or open-drain)
    function automatic logic pfs_is_alt(input logic [3:0] cfg);
        return (cfg == `PFS_CFG_ALT) || (cfg == `PFS_CFG_ALT_OD);
    endfunction

    // field selects an open-drain driver
    function automatic logic pfs_is_od(input logic [3:0] cfg);
        return (cfg == `PFS_CFG_ALT_OD) || (cfg == `PFS_CFG_OUT_OD);
    endfunction

    // field selects general-purpose output
    function automatic logic pfs_is_gpio(input logic [3:0] cfg);
        return (cfg == `PFS_CFG_OUT) || (cfg == `PFS_CFG_OUT_OD);
    endfunction

endpackage

/* File: inc/pfs_alt_if.sv */
/*
 * per-pin drive request from the routing logic to the pad bank.
 * assumes one bit per pin slot, slot numbers from pfs_cfg.svh.
 */
`timescale 1ns/10ps
`default_nettype none

interface pfs_alt_if #(
    parameter int N = 6
);
    logic [N-1:0] en;   // pin driven after the next clock edge
    logic [N-1:0] val;  // level to drive
    logic [N-1:0] od;   // open-drain: only low is driven

    modport src (output en, output val, output od);
    modport dst (input en, input val, input od);
endinterface

`default_nettype wire

/* File: hw/pfs_ser_mode.sv */
/*
 * decodes one serial controller's mode and option bits into the
 * pin roles it needs.
 * assumes mode and config inputs held stable by software.
 */
`timescale 1ns/10ps
`default_nettype none

module pfs_ser_mode
    import pfs_pkg::*;
(
    // controller settings
    input wire logic [1:0] mode,
    input wire logic spi_master_bit,
    input wire logic uart_hs_bit,
    // decoded roles
    output logic uart_hs,
    output logic spi_master,
    output logic spi_slave,
    output logic twi
);
    pfs_mode_t m;

    // role decode from mode and option bits
    always_comb begin
        m = pfs_mode_t'(mode);
        uart_hs = (m == PFS_MODE_UART) && uart_hs_bit;
        spi_master = (m == PFS_MODE_SPI) && spi_master_bit;
        spi_slave = (m == PFS_MODE_SPI) && !spi_master_bit;
        twi = (m == PFS_MODE_TWI);
    end
endmodule

`default_nettype wire

/* File: hw/pfs_pad_bank.sv */
/*
 * output registers of the pad bank: level and enable per pin, with
 * open-drain handling, plus registered pin sampling.
 * assumes pad inputs synchronous to clk; testbench resolves the wire.
 */
`timescale 1ns/10ps
`default_nettype none

module pfs_pad_bank #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // drive requests
    pfs_alt_if.dst req,
    // pads
    input wire logic [N-1:0] pad_in,
    output logic [N-1:0] pad_out,
    output logic [N-1:0] pad_oe,
    output logic [N-1:0] pin_q
);
    genvar i;

    // one driver per pin; open-drain drives only the low level
    generate
        for (i = 0; i < N; i++) begin : g_pin
            always_ff @(posedge clk) begin
                if (srst) begin
                    pad_out[i] <= 1'b0;
                    pad_oe[i] <= 1'b0;
                end else begin
                    pad_out[i] <= req.od[i] ? 1'b0 : req.val[i];
                    pad_oe[i] <= req.en[i] && !(req.od[i] && req.val[i]);
                end
            end
        end
    endgenerate

    // pin sampling for the port logic
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_q <= '0;
        end else begin
            pin_q <= pad_in;
        end
    end
endmodule

`default_nettype wire

/* File: tb/pfs_top_properties.sv */
/*
 * port checks of the pin function selector.
 * assumes a bind into pfs_top.
 */
`timescale 1ns/10ps
`default_nettype none

module pfs_top_properties #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // settings
    input wire logic [7:0] timer_two_remap,
    input wire logic [3:0] timer_two_output_enables,
    input wire logic [15:0] port_a_low_config,
    input wire logic [15:0] port_b_low_config,
    input wire logic [15:0] port_b_high_config,
    input wire logic [7:0] debug_pin_config,
    input wire logic [1:0] ser1_mode_select,
    input wire logic [7:0] ser1_spi_config,
    input wire logic [7:0] ser1_uart_config,
    // levels in
    input wire logic timer_two_ch1_out,
    input wire logic timer_two_ch3_out,
    input wire logic timer_two_ch4_out,
    input wire logic ser1_request_to_send_n,
    input wire logic ext_reg_enable,
    input wire logic [N-1:0] gpio_out,
    input wire logic [N-1:0] pad_in,
    // outputs
    input wire logic timer_one_ch4_in,
    input wire logic ser1_clear_to_send_n,
    input wire logic ser1_slave_select_n,
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe
);
    // one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_ch1_pa0;
        port_a_low_config[3:0] == 4'h9 && !timer_two_remap[4] &&
        timer_two_output_enables[0] |=>
        pad_oe[0] && pad_out[0] == $past(timer_two_ch1_out);
    endproperty
    a_ch1_pa0: assert property (p_ch1_pa0)
        else $error("timer two ch1 missing on port a pin 0");
    property p_ch3_pb3;
        port_b_low_config[15:12] == 4'h9 && timer_two_remap[6] &&
        timer_two_output_enables[2] |=>
        pad_oe[4] && pad_out[4] == $past(timer_two_ch3_out);
    endproperty
    a_ch3_pb3: assert property (p_ch3_pb3)
        else $error("timer two ch3 missing on port b pin 3");
    property p_ch4_pb4;
        port_b_high_config[3:0] == 4'h9 && timer_two_remap[7] &&
        timer_two_output_enables[3] |=>
        pad_oe[5] && pad_out[5] == $past(timer_two_ch4_out);
    endproperty
    a_ch4_pb4: assert property (p_ch4_pb4)
        else $error("timer two ch4 missing on port b pin 4");
    property p_rts;
        port_b_high_config[3:0] == 4'h9 && !timer_two_remap[7] &&
        ser1_mode_select == 2'h1 && ser1_uart_config[5] |=>
        pad_oe[5] && pad_out[5] == $past(ser1_request_to_send_n);
    endproperty
    a_rts: assert property (p_rts)
        else $error("rts missing on port b pin 4");
    property p_reg_en;
        !debug_pin_config[4] |=>
        pad_oe[3] == !$past(ext_reg_enable) && !pad_out[3];
    endproperty
    a_reg_en: assert property (p_reg_en)
        else $error("regulator enable wrong on port a pin 7");
    property p_t1_in;
        pad_in[3] |=> timer_one_ch4_in ##1 timer_one_ch4_in == $past(pad_in[3]);
    endproperty
    a_t1_in: assert property (p_t1_in)
        else $error("timer one ch4 input not from port a pin 7");
    property p_ssel;
        ser1_mode_select == 2'h2 && !ser1_spi_config[4] |=>
        ser1_slave_select_n == $past(pad_in[5]);
    endproperty
    a_ssel: assert property (p_ssel)
        else $error("slave select not from port b pin 4");
    property p_cts_off;
        (ser1_mode_select != 2'h1) [*2] |-> !ser1_clear_to_send_n;
    endproperty
    a_cts_off: assert property (p_cts_off)
        else $error("cts active outside uart mode");
    property p_gpio_out;
        port_a_low_config[3:0] == 4'h1 |=>
        pad_oe[0] && pad_out[0] == $past(gpio_out[0]);
    endproperty
    a_gpio_out: assert property (p_gpio_out)
        else $error("port logic not driving port a pin 0");

    // main scenarios reached
    c_remap: cover property (timer_two_remap[6] && pad_oe[4]);
    c_reg_off: cover property (debug_pin_config[4] && pad_oe[3]);
    c_slave: cover property (!ser1_slave_select_n);
endmodule

`default_nettype wire

/* File: tb/pfs_top_test.sv */
/*
 * directed bench of the pin function selector.
 * assumes pfs_top and its checker compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none

module pfs_top_test;
    logic clk, srst, ext_reg_enable;
    logic [7:0] timer_two_remap, debug_pin_config, ser1_uart_config;
    logic [7:0] ser1_spi_config, ser2_spi_config;
    logic [3:0] timer_two_output_enables, timer_one_output_enables;
    logic [15:0] port_a_low_config, port_a_high_config;
    logic [15:0] port_b_low_config, port_b_high_config;
    logic [1:0] ser1_mode_select, ser2_mode_select;
    logic timer_two_ch1_out, timer_two_ch3_out, timer_two_ch4_out;
    logic timer_one_ch4_out, ser1_spi_clock_out, ser1_request_to_send_n;
    logic ser2_spi_mosi_out, ser2_spi_miso_out, ser2_twowire_data_out;
    logic [5:0] gpio_out, pad_in, gpio_in, pad_out, pad_oe;
    logic timer_two_ch1_in, timer_two_ch3_in, timer_two_ch4_in;
    logic timer_one_ch4_in, ser1_spi_clock_in, ser1_clear_to_send_n;
    logic ser1_slave_select_n, ser2_spi_mosi_in, ser2_spi_miso_in;
    logic ser2_twowire_data_in;
    int error_cnt = 0;
    int checks = 0;

    pfs_top DUT (.*);

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare one value
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // all inputs but clock and reset to zero
    task automatic idle;
        {timer_two_remap, debug_pin_config, ser1_uart_config, ser1_spi_config,
         ser2_spi_config, timer_two_output_enables, timer_one_output_enables,
         port_a_low_config, port_a_high_config, port_b_low_config,
         port_b_high_config, ser1_mode_select, ser2_mode_select,
         timer_two_ch1_out, timer_two_ch3_out, timer_two_ch4_out,
         timer_one_ch4_out, ser1_spi_clock_out, ser1_request_to_send_n,
         ser2_spi_mosi_out, ser2_spi_miso_out, ser2_twowire_data_out,
         ext_reg_enable, gpio_out, pad_in} <= '0;
    endtask

    // clear, then free an edge
    task automatic fresh;
        @(posedge clk);
        idle();
        @(posedge clk);
    endtask

    // one edge to take settings, then look
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        idle();
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("oe_in_reset", pad_oe, 0);
        chk("ssel_in_reset", ser1_slave_select_n, 1);
        chk("twi_in_reset", ser2_twowire_data_in, 1);
        // regulator enable after reset
        settle();
        chk("reg_oe", pad_oe[3], 1);
        chk("reg_out", pad_out[3], 0);
        @(posedge clk);
        ext_reg_enable <= 1'b1;
        settle();
        chk("reg_rel_oe", pad_oe[3], 0);
        // port a pin 0 owners
        fresh();
        port_a_low_config <= 16'h0009;
        timer_two_output_enables <= 4'h1;
        timer_two_ch1_out <= 1'b1;
        pad_in <= 6'h01;
        ser2_mode_select <= 2'h2;
        ser2_spi_config <= 8'h10;
        settle();
        chk("pa0_t2c1", {pad_oe[0], pad_out[0]}, 2'b11);
        chk("t2c1_in", timer_two_ch1_in, 1);
        @(posedge clk);
        timer_two_remap <= 8'h10;
        settle();
        chk("pa0_mosi_remap", {pad_oe[0], pad_out[0]}, 2'b10);
        chk("t2c1_in_off", timer_two_ch1_in, 0);
        @(posedge clk);
        timer_two_remap <= 8'h00;
        timer_two_output_enables <= 4'h0;
        ser2_spi_mosi_out <= 1'b1;
        settle();
        chk("pa0_mosi_oeoff", {pad_oe[0], pad_out[0]}, 2'b11);
        @(posedge clk);
        port_a_low_config <= 16'h0004;
        settle();
        chk("pa0_input_cfg", pad_oe[0], 0);
        @(posedge clk);
        port_a_low_config <= 16'h0001;
        gpio_out <= 6'h01;
        settle();
        chk("pa0_gpio", {pad_oe[0], pad_out[0]}, 2'b11);
        // channel 3 on port a pin 1 or port b pin 3
        fresh();
        port_a_low_config <= 16'h0090;
        port_b_low_config <= 16'h9000;
        timer_two_output_enables <= 4'h4;
        timer_two_ch3_out <= 1'b1;
        ser1_mode_select <= 2'h2;
        ser1_spi_config <= 8'h10;
        settle();
        chk("pa1_t2c3", {pad_oe[1], pad_out[1]}, 2'b11);
        chk("pb3_sclk", {pad_oe[4], pad_out[4]}, 2'b10);
        @(posedge clk);
        timer_two_remap <= 8'h40;
        port_a_low_config <= 16'h00d0;
        ser2_mode_select <= 2'h3;
        pad_in <= 6'h10;
        settle();
        chk("pb3_t2c3", {pad_oe[4], pad_out[4]}, 2'b11);
        chk("pa1_twi_low", {pad_oe[1], pad_out[1]}, 2'b10);
        chk("t2c3_in", timer_two_ch3_in, 1);
        chk("twi_in", ser2_twowire_data_in, 0);
        @(posedge clk);
        ser2_twowire_data_out <= 1'b1;
        settle();
        chk("pa1_twi_high", pad_oe[1], 0);
        @(posedge clk);
        ser2_twowire_data_out <= 1'b0;
        port_a_low_config <= 16'h0090;
        settle();
        chk("pa1_twi_pushpull", pad_oe[1], 0);
        // channel 4, then handshake
        fresh();
        port_b_high_config <= 16'h0009;
        port_a_low_config <= 16'h0900;
        timer_two_output_enables <= 4'h8;
        timer_two_ch4_out <= 1'b1;
        timer_two_remap <= 8'h80;
        ser1_mode_select <= 2'h1;
        ser1_uart_config <= 8'h20;
        settle();
        chk("pb4_t2c4", {pad_oe[5], pad_out[5]}, 2'b11);
        chk("pa2_unowned", pad_oe[2], 0);
        @(posedge clk);
        timer_two_remap <= 8'h00;
        pad_in <= 6'h14;
        settle();
        chk("pa2_t2c4", {pad_oe[2], pad_out[2]}, 2'b11);
        chk("pb4_rts", {pad_oe[5], pad_out[5]}, 2'b10);
        chk("t2c4_in", timer_two_ch4_in, 1);
        chk("cts_on", ser1_clear_to_send_n, 1);
        @(posedge clk);
        ser1_uart_config <= 8'h00;
        settle();
        chk("cts_off", ser1_clear_to_send_n, 0);
        chk("pb4_rts_off", pad_oe[5], 0);
        // spi slave then master directions
        fresh();
        ser1_mode_select <= 2'h2;
        ser2_mode_select <= 2'h2;
        port_a_low_config <= 16'h0090;
        ser2_spi_miso_out <= 1'b1;
        pad_in <= 6'h11;
        settle();
        chk("ssel", ser1_slave_select_n, 0);
        chk("sclk_in", ser1_spi_clock_in, 1);
        chk("mosi_in", ser2_spi_mosi_in, 1);
        chk("pa1_miso", {pad_oe[1], pad_out[1]}, 2'b11);
        @(posedge clk);
        ser2_spi_config <= 8'h10;
        pad_in <= 6'h02;
        settle();
        chk("miso_in", ser2_spi_miso_in, 1);
        chk("pa1_master", pad_oe[1], 0);
        // pin 7 released to timer one
        fresh();
        debug_pin_config <= 8'h10;
        port_a_high_config <= 16'h9000;
        timer_one_output_enables <= 4'h8;
        timer_one_ch4_out <= 1'b1;
        pad_in <= 6'h08;
        settle();
        chk("pa7_t1c4", {pad_oe[3], pad_out[3]}, 2'b11);
        chk("t1c4_in", timer_one_ch4_in, 1);
        chk("gpio_in", gpio_in, 8'h08);
        test_done();
    end
endmodule

bind pfs_top pfs_top_properties #(.N(N)) u_props (.*);

`default_nettype wire
